// ===== logic/blink_coder.sv
`timescale 1ns/1ps
`include "front_panel_cfg.svh"

module blink_coder
    import front_panel_pkg::*;
#(
    parameter int unsigned PAUSE_SLOTS = `FP_PAUSE_SLOTS
) (
    input wire logic i_clk_sys, // System clock
    input wire logic i_rst_n, // Synchronous reset, active low
    input wire logic i_ce, // Clock enable
    input wire logic i_tick, // One pulse per blink slot
    input wire logic [2:0] i_code, // Pattern code
    output logic o_lit // Indicator level
);

    // --
    // Slot position within the pattern frame
    // --
    logic [4:0] pos; // Current slot
    logic [2:0] last_code; // Code seen in the previous cycle
    logic [4:0] frame_len; // Slots per frame for the code

    generate
        if (PAUSE_SLOTS < 1 || PAUSE_SLOTS > 16) begin : g_bad_pause
            $error("blink_coder: PAUSE_SLOTS out of range");
        end
    endgenerate

    // N flashes of one slot on and one off, then a dark pause
    assign frame_len = 5'({i_code, 1'b0}) + 5'(PAUSE_SLOTS);

    // Advance slot; restart the frame when the code changes
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            pos <= 5'h00;
            last_code <= 3'h0;
        end else if (i_ce) begin
            last_code <= i_code;
            if (i_code != last_code) begin
                pos <= 5'h00; // New code starts clean
            end else if (i_tick) begin
                pos <= (pos >= frame_len - 5'h01) ? 5'h00 : pos + 5'h01; // RL19
            end
        end
    end

    // Output level from code and slot
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_lit <= 1'b0;
        end else if (i_ce) begin
            if (i_code == LED_STEADY) begin
                o_lit <= 1'b1; // Steady on
            end else if (i_code >= LED_1X && i_code <= LED_4X) begin
                o_lit <= (pos < 5'({i_code, 1'b0})) && !pos[0]; // RL19
            end else begin
                o_lit <= 1'b0; // Dark or unused code
            end
        end
    end

endmodule : blink_coder

// ===== logic/front_panel_cfg.svh
`ifndef FRONT_PANEL_CFG_SVH
`define FRONT_PANEL_CFG_SVH

// --
// Clock and timing (times in milliseconds)
// --
`define FP_CLK_HZ 20000000
`define FP_T_DEBOUNCE_MS 20
`define FP_T_SHORT_MS 1000
`define FP_T_LONG_MS 3000
`define FP_T_LONGER_MS 10000
`define FP_T_POWERUP_MS 3000
`define FP_T_START_MS 5000
`define FP_T_SLOT_MS 250
`define FP_PAUSE_SLOTS 4

// --
// Beep counts at each hold threshold and at power-up
// --
`define FP_BEEPS_SHORT 3'h1
`define FP_BEEPS_LONG 3'h2
`define FP_BEEPS_LONGER 3'h5
`define FP_BEEPS_POWERUP 3'h1

// --
// Register byte offsets
// --
`define FP_REG_CTRL 4'h0
`define FP_REG_CMD 4'h4
`define FP_REG_CODES 4'h8
`define FP_REG_STATUS 4'hC

// --
// Field positions
// --
`define FP_CTRL_BTN_EN 0
`define FP_CTRL_BUZZ_EN 1
`define FP_CTRL_CFG_DONE 2
`define FP_CTRL_IDENTIFY 3
`define FP_CTRL_FLEX_SRC 4
`define FP_CMD_ONOFF 0
`define FP_CMD_CLEAR 1
`define FP_CODES_WHITE 0
`define FP_CODES_RED 4
`define FP_CODES_SRC 8
`define FP_CODES_FLEX 12

// --
// Reset values
// --
`define FP_CTRL_RST 5'h03
`define FP_CODES_RST 16'h0000

`endif

// ===== logic/front_panel_pkg.sv
package front_panel_pkg;

    // Unit operating state
    typedef enum logic [1:0] {
        ST_POWERUP = 2'b00,
        ST_OFF = 2'b01,
        ST_STARTING = 2'b10,
        ST_ON = 2'b11
    } unit_state_t;

    // Indicator pattern code
    typedef enum logic [2:0] {
        LED_DARK = 3'b000,
        LED_1X = 3'b001,
        LED_2X = 3'b010,
        LED_3X = 3'b011,
        LED_4X = 3'b100,
        LED_STEADY = 3'b101
    } led_code_t;

endpackage : front_panel_pkg

// ===== logic/front_panel_ui.sv
// How it works
// RL1 - Impulse release clears errors, silences buzzer
// RL2 - Release after 1-3 s toggles unit
// RL3 - One beep at one second hold
// RL4 - Release after 3-10 s does nothing
// RL5 - Two beeps at three seconds hold
// RL6 - Hold beyond ten seconds resets system
// RL7 - Five beeps at ten seconds hold
// RL8 - Setting disables button; presses ignored
// RL9 - Power-up: beep, all lit, then off
// RL10 - No operation before initial configuration
// RL11 - Start converters, red off once on
// RL12 - White: off, steady, 1x standby, 2x restart
// RL13 - Red off running, steady when unit off
// RL14 - Red flashes 1-4 give error class
// RL15 - Source indicator off, steady, 1-4 flashes
// RL16 - Flex-as-source indicator like source indicator
// RL17 - Buzzer follows red code; can be disabled
// RL18 - Power-up blink all; identify blinks all (code lights all steady at power-up)
// RL19 - N flashes then longer dark pause
// RL20 - Synchronise and debounce button first
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "front_panel_cfg.svh"

module front_panel_ui
    import front_panel_pkg::*;
#(
    parameter int unsigned CLK_HZ = `FP_CLK_HZ,
    parameter int unsigned DEBOUNCE_CYC = `FP_T_DEBOUNCE_MS * (CLK_HZ / 1000),
    parameter int unsigned SHORT_CYC = `FP_T_SHORT_MS * (CLK_HZ / 1000),
    parameter int unsigned LONG_CYC = `FP_T_LONG_MS * (CLK_HZ / 1000),
    parameter int unsigned LONGER_CYC = `FP_T_LONGER_MS * (CLK_HZ / 1000),
    parameter int unsigned POWERUP_CYC = `FP_T_POWERUP_MS * (CLK_HZ / 1000),
    parameter int unsigned START_CYC = `FP_T_START_MS * (CLK_HZ / 1000),
    parameter int unsigned SLOT_CYC = `FP_T_SLOT_MS * (CLK_HZ / 1000)
) (
    input wire logic i_clk_sys, // System clock, 20 MHz
    input wire logic i_rst_n, // Synchronous reset, active low
    input wire logic i_ce, // Clock enable, freezes all state when low
    input wire logic i_button, // Front button, high while pressed
    input wire logic [3:0] i_address, // Avalon byte address
    input wire logic i_read, // Avalon read
    input wire logic i_write, // Avalon write
    input wire logic [31:0] i_writedata, // Avalon write data
    input wire logic [3:0] i_byteenable, // Avalon byte enables
    output logic [31:0] o_readdata, // Avalon read data
    output logic o_waitrequest, // Avalon wait request
    output logic o_led_white, // Central white indicator
    output logic o_led_red, // Central red indicator
    output logic o_led_src, // AC-source indicator
    output logic o_led_flex, // Flex-as-source indicator
    output logic o_buzzer, // Buzzer drive
    output logic o_unit_on, // Load output, source and flex enabled
    output logic o_clear_errors, // One-cycle request to clear errors
    output logic o_sys_reset // One-cycle reset request to all devices
);

    // --
    // Declarations
    // --
    unit_state_t state; // Operating state
    logic [31:0] state_cnt; // Time in power-up or start state
    logic btn_s1, btn_s2; // Button synchroniser
    logic btn_db; // Debounced button level
    logic [31:0] db_cnt; // Debounce counter
    logic [31:0] hold_cnt; // Hold duration of current press
    logic btn_toggle; // Short press release
    logic btn_impulse; // Impulse press release
    logic [31:0] slot_cnt; // Blink slot divider
    logic slot_tick; // One pulse per slot
    logic [2:0] beeps_left; // Remaining beeps in a burst
    logic beep_gap; // Burst in its silent half
    logic ident_phase; // Identify blink phase
    logic silenced; // Buzzer silenced by impulse press
    logic [4:0] ctrl; // Control register
    logic [15:0] codes; // Status code register
    logic ack; // Bus answer cycle
    logic req; // Bus request present
    logic cmd_toggle; // Software on/off request
    logic [2:0] disp_code [4]; // Codes shown on white, red, source, flex
    logic [3:0] lit; // Pattern levels from coders
    logic [2:0] last_red; // Red code of previous cycle

    generate
        if (SHORT_CYC < 1 || SHORT_CYC >= LONG_CYC || LONG_CYC >= LONGER_CYC ||
            SLOT_CYC < 1 || DEBOUNCE_CYC < 1 || POWERUP_CYC < 1 || START_CYC < 1)
        begin : g_bad_timing
            $error("front_panel_ui: timing parameters out of order");
        end
    endgenerate

    // Decode a register offset
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
        hit = (addr == off);
    endfunction : hit

    // --
    // Avalon-MM slave
    // --
    assign req = i_read || i_write;
    assign o_waitrequest = req && !ack; // One wait cycle per access
    assign cmd_toggle = i_write && ack && hit(i_address, `FP_REG_CMD) &&
        i_byteenable[0] && i_writedata[`FP_CMD_ONOFF];

    // Answer each request on its second cycle
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ack <= 1'b0;
        end else if (i_ce) begin
            ack <= req && !ack;
        end
    end

    // Read data stands from the answer edge
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_readdata <= 32'h0;
        end else if (i_ce && i_read && !ack) begin
            if (hit(i_address, `FP_REG_CTRL)) begin
                o_readdata <= {27'h0, ctrl};
            end else if (hit(i_address, `FP_REG_CODES)) begin
                o_readdata <= {16'h0, codes};
            end else if (hit(i_address, `FP_REG_STATUS)) begin
                o_readdata <= {26'h0, (beeps_left != 3'h0), silenced, o_unit_on,
                    btn_db, state};
            end else begin
                o_readdata <= 32'h0; // Command and unmapped read zero
            end
        end
    end

    // Control and code registers
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ctrl <= `FP_CTRL_RST;
            codes <= `FP_CODES_RST;
        end else if (i_ce && i_write && ack) begin
            if (hit(i_address, `FP_REG_CTRL)) begin
                if (i_byteenable[0]) begin
                    ctrl <= i_writedata[4:0]; // RL8 RL17
                end
            end else if (hit(i_address, `FP_REG_CODES)) begin
                if (i_byteenable[0]) begin
                    codes[7:0] <= i_writedata[7:0];
                end
                if (i_byteenable[1]) begin
                    codes[15:8] <= i_writedata[15:8];
                end
            end
        end
    end

    // --
    // Button conditioning
    // --
    // Two-stage synchroniser
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            btn_s1 <= 1'b0;
            btn_s2 <= 1'b0;
        end else if (i_ce) begin
            btn_s1 <= i_button; // RL20
            btn_s2 <= btn_s1;
        end
    end

    // Take a level once stable for the debounce time
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            btn_db <= 1'b0;
            db_cnt <= 32'h0;
        end else if (i_ce) begin
            if (btn_s2 == btn_db) begin
                db_cnt <= 32'h0;
            end else if (db_cnt >= DEBOUNCE_CYC - 1) begin
                btn_db <= btn_s2; // RL20
                db_cnt <= 32'h0;
            end else begin
                db_cnt <= db_cnt + 32'h1;
            end
        end
    end

    // Measure the hold; classify the press on release
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            hold_cnt <= 32'h0;
            btn_toggle <= 1'b0;
            btn_impulse <= 1'b0;
            o_sys_reset <= 1'b0;
        end else if (i_ce) begin
            btn_toggle <= 1'b0;
            btn_impulse <= 1'b0;
            o_sys_reset <= 1'b0;
            if (!ctrl[`FP_CTRL_BTN_EN] || state == ST_POWERUP) begin
                hold_cnt <= 32'h0; // RL8
            end else if (btn_db) begin
                if (hold_cnt < LONGER_CYC) begin
                    hold_cnt <= hold_cnt + 32'h1;
                end
                o_sys_reset <= (hold_cnt == LONGER_CYC - 1); // RL6
            end else if (hold_cnt != 32'h0) begin
                hold_cnt <= 32'h0;
                if (hold_cnt < SHORT_CYC) begin
                    btn_impulse <= 1'b1; // RL1
                end else if (hold_cnt < LONG_CYC) begin
                    btn_toggle <= 1'b1; // RL2
                end
                // Longer holds end with no action RL4
            end
        end
    end

    // --
    // Unit state
    // --
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state <= ST_POWERUP;
            state_cnt <= 32'h0;
        end else if (i_ce) begin
            state_cnt <= state_cnt + 32'h1;
            case (state)
                ST_POWERUP: begin
                    if (state_cnt >= POWERUP_CYC - 1) begin
                        state <= ST_OFF; // RL9
                    end
                end
                ST_OFF: begin
                    if ((btn_toggle || cmd_toggle) && ctrl[`FP_CTRL_CFG_DONE]) begin
                        state <= ST_STARTING; // RL10
                        state_cnt <= 32'h0;
                    end
                end
                ST_STARTING: begin
                    if (btn_toggle || cmd_toggle) begin
                        state <= ST_OFF;
                    end else if (state_cnt >= START_CYC - 1) begin
                        state <= ST_ON; // RL11
                    end
                end
                ST_ON: begin
                    if (btn_toggle || cmd_toggle) begin
                        state <= ST_OFF; // RL2
                    end
                end
                default: begin
                    state <= ST_OFF;
                end
            endcase
        end
    end

    // Unit enable and error clear request
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_unit_on <= 1'b0;
            o_clear_errors <= 1'b0;
        end else if (i_ce) begin
            o_unit_on <= (state == ST_STARTING) || (state == ST_ON); // RL9 RL11
            o_clear_errors <= btn_impulse || (i_write && ack &&
                hit(i_address, `FP_REG_CMD) && i_byteenable[0] &&
                i_writedata[`FP_CMD_CLEAR]); // RL1
        end
    end

    // --
    // Slot timing and beeps
    // --
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            slot_cnt <= 32'h0;
            slot_tick <= 1'b0;
            ident_phase <= 1'b0;
        end else if (i_ce) begin
            slot_tick <= (slot_cnt == SLOT_CYC - 1);
            slot_cnt <= (slot_cnt >= SLOT_CYC - 1) ? 32'h0 : slot_cnt + 32'h1;
            if (slot_tick) begin
                ident_phase <= !ident_phase;
            end
        end
    end

    // Beep bursts at hold thresholds and at power-up
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            beeps_left <= `FP_BEEPS_POWERUP; // RL9
            beep_gap <= 1'b0;
        end else if (i_ce) begin
            if (btn_db && hold_cnt == SHORT_CYC - 1) begin
                beeps_left <= `FP_BEEPS_SHORT; // RL3
                beep_gap <= 1'b0;
            end else if (btn_db && hold_cnt == LONG_CYC - 1) begin
                beeps_left <= `FP_BEEPS_LONG; // RL5
                beep_gap <= 1'b0;
            end else if (btn_db && hold_cnt == LONGER_CYC - 1) begin
                beeps_left <= `FP_BEEPS_LONGER; // RL7
                beep_gap <= 1'b0;
            end else if (slot_tick && beeps_left != 3'h0) begin
                beep_gap <= !beep_gap;
                if (beep_gap) begin
                    beeps_left <= beeps_left - 3'h1;
                end
            end
        end
    end

    // Impulse silences until red code changes
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            silenced <= 1'b0;
            last_red <= 3'h0;
        end else if (i_ce) begin
            last_red <= disp_code[1];
            if (btn_impulse) begin
                silenced <= 1'b1; // RL1
            end else if (disp_code[1] != last_red) begin
                silenced <= 1'b0;
            end
        end
    end

    // --
    // Indicator codes and pattern coders
    // --
    always_comb begin
        disp_code[0] = LED_DARK;
        disp_code[1] = LED_STEADY;
        disp_code[2] = codes[`FP_CODES_SRC +: 3]; // RL15
        disp_code[3] = ctrl[`FP_CTRL_FLEX_SRC] ? codes[`FP_CODES_FLEX +: 3] : LED_DARK; // RL16
        if (state == ST_ON) begin
            disp_code[0] = (codes[`FP_CODES_WHITE +: 3] == LED_DARK) ? LED_STEADY :
                codes[`FP_CODES_WHITE +: 3]; // RL12
            disp_code[1] = codes[`FP_CODES_RED +: 3]; // RL13 RL14
        end else if (state == ST_STARTING) begin
            disp_code[0] = LED_STEADY;
        end
        if (state != ST_ON && state != ST_STARTING) begin
            disp_code[2] = LED_DARK; // Source connection disabled while off
            disp_code[3] = LED_DARK; // Flex disabled while off
        end
    end

    generate
        for (genvar g = 0; g < 4; g++) begin : g_coder
            blink_coder #(
                .PAUSE_SLOTS(`FP_PAUSE_SLOTS)
            ) u_coder (
                .i_clk_sys(i_clk_sys),
                .i_rst_n(i_rst_n),
                .i_ce(i_ce),
                .i_tick(slot_tick),
                .i_code(disp_code[g]),
                .o_lit(lit[g])
            );
        end
    endgenerate

    // Lamp and buzzer drive
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_led_white <= 1'b0;
            o_led_red <= 1'b0;
            o_led_src <= 1'b0;
            o_led_flex <= 1'b0;
            o_buzzer <= 1'b0;
        end else if (i_ce) begin
            if (state == ST_POWERUP) begin
                {o_led_white, o_led_red, o_led_src, o_led_flex} <= 4'hF; // RL9 RL18
            end else if (ctrl[`FP_CTRL_IDENTIFY]) begin
                {o_led_white, o_led_red, o_led_src, o_led_flex} <= {4{ident_phase}}; // RL18
            end else begin
                {o_led_white, o_led_red, o_led_src, o_led_flex} <= {lit[0], lit[1],
                    lit[2], lit[3]};
            end
            if (beeps_left != 3'h0) begin
                o_buzzer <= !beep_gap; // RL3 RL5 RL7
            end else begin
                o_buzzer <= ctrl[`FP_CTRL_BUZZ_EN] && !silenced &&
                    (state == ST_ON) && lit[1]; // RL17
            end
        end
    end

endmodule : front_panel_ui

// ===== verif/fp_panel_model.sv
`timescale 1ns/1ps
module fp_panel_model (
    input wire logic i_clk_sys, // Clock
    input wire logic [6:0] i_seen, // Lamps, buzzer and pulses
    output logic o_button // Button, high = pressed
);
    int rises[7]; // Rising edges per watched line
    logic [6:0] prev_seen = 7'h00; // Levels one edge ago
    initial o_button = 1'b0;
    // Count rising edges
    always @(posedge i_clk_sys) begin
        for (int i = 0; i < 7; i++) begin
            if (i_seen[i] && !prev_seen[i]) begin
                rises[i] <= rises[i] + 1;
            end
        end
        prev_seen <= i_seen;
    end
    // Bounced press, hold, release
    task automatic press(input int cyc);
        o_button <= 1'b1;
        @(posedge i_clk_sys);
        o_button <= 1'b0;
        @(posedge i_clk_sys);
        o_button <= 1'b1;
        repeat (cyc) @(posedge i_clk_sys);
        o_button <= 1'b0;
        repeat (16) @(posedge i_clk_sys);
    endtask : press
endmodule : fp_panel_model

// ===== verif/front_panel_ui_bench.sv
`timescale 1ns/1ps
`include "front_panel_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("BAD %0t got %0h want %0h", $time, (g), (e)); end end

module front_panel_ui_bench;
    logic i_clk_sys, i_rst_n, i_read, i_write, i_button, i_ce;
    logic [3:0] i_address, i_byteenable;
    logic [31:0] i_writedata, o_readdata, rd;
    logic o_waitrequest, o_led_white, o_led_red, o_led_src, o_led_flex;
    logic o_buzzer, o_unit_on, o_clear_errors, o_sys_reset;
    int err_count, cmp_count, base[7];

    front_panel_ui #(.DEBOUNCE_CYC(2), .SHORT_CYC(20), .LONG_CYC(60), .LONGER_CYC(200),
        .POWERUP_CYC(30), .START_CYC(40), .SLOT_CYC(4)) uut (.i_clk_sys, .i_rst_n, .i_ce,
        .i_button, .i_address, .i_read, .i_write, .i_writedata, .i_byteenable, .o_readdata,
        .o_waitrequest, .o_led_white, .o_led_red, .o_led_src, .o_led_flex, .o_buzzer,
        .o_unit_on, .o_clear_errors, .o_sys_reset);
    fp_panel_model pm (.i_clk_sys, .o_button(i_button), .i_seen({o_sys_reset,
        o_clear_errors, o_led_flex, o_led_src, o_led_white, o_led_red, o_buzzer}));

    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end
    // One bus transfer
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        i_address <= a;
        i_writedata <= d;
        i_write <= wr;
        i_read <= !wr;
        do @(posedge i_clk_sys); while (o_waitrequest !== 1'b0);
        rd = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
        @(posedge i_clk_sys);
    endtask : bus
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : cyc
    function automatic int d(input int i);
        return pm.rises[i] - base[i];
    endfunction : d
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done
    // Power-up and registers
    task automatic t_power;
        `CHK({o_led_white, o_led_red, o_led_src, o_led_flex}, 4'hF)
        bus(1'b0, `FP_REG_CTRL, 32'h0);
        `CHK(rd, {27'h0, `FP_CTRL_RST})
        cyc(40);
        `CHK({o_led_white, o_led_red, o_led_src, o_led_flex, o_unit_on}, 5'h08)
        bus(1'b1, `FP_REG_STATUS, 32'hFF);
        bus(1'b0, `FP_REG_STATUS, 32'h0);
        `CHK(rd, 32'h1)
        bus(1'b0, `FP_REG_CMD, 32'h0);
        `CHK(rd, 32'h0)
        pm.press(30);
        `CHK(o_unit_on, 1'b0)
    endtask : t_power
    // Short press starts the unit
    task automatic t_on;
        bus(1'b1, `FP_REG_CTRL, 32'h17);
        base = pm.rises;
        pm.press(30);
        `CHK(d(0), 1)
        `CHK(o_unit_on, 1'b1)
        cyc(45);
        `CHK({o_led_red, o_led_white}, 2'b01)
    endtask : t_on
    // Flash codes
    task automatic t_codes;
        for (int n = 1; n < 6; n++) begin
            bus(1'b1, `FP_REG_CODES, 32'h0);
            cyc(4);
            base = pm.rises;
            bus(1'b1, `FP_REG_CODES, {16'h0, {4{1'b0, n[2:0]}}});
            cyc(8 * n + 10);
            for (int i = 0; i < 5; i++) begin
                if (i != 2) begin
                    `CHK(d(i), n < 5 ? n : 1)
                end
            end
        end
    endtask : t_codes
    // Silencing
    task automatic t_quiet;
        bus(1'b1, `FP_REG_CODES, 32'h40);
        base = pm.rises;
        pm.press(6);
        `CHK(d(5), 1)
        base = pm.rises;
        cyc(60);
        `CHK(d(0), 0)
        bus(1'b1, `FP_REG_CTRL, 32'h15);
        bus(1'b1, `FP_REG_CODES, 32'h30);
        base = pm.rises;
        cyc(60);
        `CHK({d(0) == 0, d(1) > 0}, 2'b11)
        bus(1'b1, `FP_REG_CTRL, 32'h17);
        bus(1'b1, `FP_REG_CODES, 32'h0);
        i_byteenable <= 4'h2;
        bus(1'b1, `FP_REG_CODES, 32'hFFFF_7777);
        i_byteenable <= 4'hF;
        bus(1'b0, `FP_REG_CODES, 32'h0);
        `CHK(rd, 32'h7700)
    endtask : t_quiet
    // Long presses
    task automatic t_long;
        base = pm.rises;
        pm.press(100);
        `CHK({d(0), 32'(o_unit_on)}, {32'd3, 32'd1})
        base = pm.rises;
        pm.press(250);
        cyc(30);
        `CHK(d(0), 8)
        `CHK(d(6), 1)
        bus(1'b1, `FP_REG_CTRL, 32'h16);
        base = pm.rises;
        pm.press(30);
        `CHK({d(0) == 0, o_unit_on}, 2'b11)
        bus(1'b1, `FP_REG_CTRL, 32'h17);
        pm.press(30);
        `CHK({o_unit_on, o_led_red}, 2'b01)
        i_ce <= 1'b0;
        base = pm.rises;
        pm.press(10);
        i_ce <= 1'b1;
        `CHK(d(5), 0)
    endtask : t_long
    initial begin
        i_rst_n = 1'b0;
        i_read = 1'b0;
        i_write = 1'b0;
        i_address = 4'h0;
        i_writedata = 32'h0;
        i_byteenable = 4'hF;
        i_ce = 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        t_power();
        t_on();
        t_codes();
        t_quiet();
        t_long();
        test_done();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        err_count++;
        test_done();
    end
endmodule : front_panel_ui_bench

// ===== verif/front_panel_ui_sva.sv
`timescale 1ns/1ps
module front_panel_ui_sva #(
    parameter int unsigned SHORT_CYC = 20, // Short-press threshold
    parameter int unsigned LONG_CYC = 60, // Long-press threshold
    parameter int unsigned LONGER_CYC = 200 // Reset threshold
) (
    input wire logic i_clk_sys, // Clock
    input wire logic i_rst_n, // Reset, active low
    input wire logic i_button, // Raw button
    input wire logic i_read, // Bus read
    input wire logic i_write, // Bus write
    input wire logic [3:0] i_address, // Bus address
    input wire logic [31:0] i_writedata, // Bus write data
    input wire logic o_waitrequest, // Bus stall
    input wire logic o_led_white, // White lamp
    input wire logic o_led_red, // Red lamp
    input wire logic o_led_src, // Source lamp
    input wire logic o_led_flex, // Flex lamp
    input wire logic o_buzzer, // Buzzer
    input wire logic o_unit_on, // Unit running
    input wire logic o_clear_errors, // Clear pulse
    input wire logic o_sys_reset // Reset pulse
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    int held; // Raw cycles the button is held
    int last; // Length of the last completed press
    int wr_age; // Cycles since the last bus write
    logic btn_en; // Button enable as last written
    // Press length tracking
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || !i_button) begin
            held <= 0;
        end else if (held < 1000) begin
            held <= held + 1;
        end
        if (!i_rst_n) begin
            last <= 1000;
        end else if (!i_button && held != 0) begin
            last <= held;
        end
    end
    // Bus write history
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            wr_age <= 100;
            btn_en <= 1'b1;
        end else if (i_write) begin
            wr_age <= 0;
            if (!o_waitrequest && i_address == 4'h0) begin
                btn_en <= i_writedata[0];
            end
        end else if (wr_age < 100) begin
            wr_age <= wr_age + 1;
        end
    end
    AST_BUS_ONE_WAIT: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
        else $error("bus answer late");
    AST_POWERUP_LIT: assert property (
        $rose(i_rst_n) |-> ##[1:2] (o_led_white && o_led_red && o_led_src && o_led_flex))
        else $error("lamps not lit at power-up");
    AST_CLEAR_SHORT: assert property (
        o_clear_errors |-> (last < SHORT_CYC + 3 || wr_age < 6) ##1 !o_clear_errors)
        else $error("clear pulse without impulse press");
    AST_TOGGLE_WINDOW: assert property (
        $rose(o_unit_on) |-> (last + 4 > SHORT_CYC && last < LONG_CYC + 4) || wr_age < 8)
        else $error("unit started without short press");
    AST_LONG_NOOP: assert property (
        $fell(i_button) && held >= LONG_CYC + 4 |=> $stable(o_unit_on) [*8])
        else $error("long press changed unit");
    AST_SHORT_BEEP: assert property (
        btn_en && i_button && held == SHORT_CYC + 2 |-> ##[0:8] o_buzzer)
        else $error("no beep at short threshold");
    AST_LONG_BEEP: assert property (
        btn_en && i_button && held == LONG_CYC + 2 |-> ##[0:8] o_buzzer)
        else $error("no beep at long threshold");
    AST_RESET_HELD: assert property (
        o_sys_reset |-> btn_en && held >= LONGER_CYC ##1 !o_sys_reset)
        else $error("reset pulse wrong");
    AST_RESET_BEEP: assert property (o_sys_reset |-> ##[0:2] o_buzzer)
        else $error("no beep with reset");
    AST_BTN_OFF: assert property (
        !btn_en && $fell(i_button) |=> (!o_clear_errors && $stable(o_unit_on)) [*8])
        else $error("disabled button acted");
    AST_OFF_RED: assert property ($fell(o_unit_on) |-> ##[0:3] o_led_red)
        else $error("red dark while off");
endmodule : front_panel_ui_sva

bind front_panel_ui front_panel_ui_sva #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC),
    .LONGER_CYC(LONGER_CYC)) chk (.i_clk_sys, .i_rst_n, .i_button, .i_read, .i_write,
    .i_address, .i_writedata, .o_waitrequest, .o_led_white, .o_led_red, .o_led_src,
    .o_led_flex, .o_buzzer, .o_unit_on, .o_clear_errors, .o_sys_reset);
